// [adcsr_readout.v]
// Serial readout of a 16-bit sampling converter in select and chain modes.
// Notes on behaviour
// - High input at convert edge: start, select, float.
// - Input level at convert edge picks the mode.
// - Conversion runs to end regardless of convert.
// - After conversion, acquire and power down.
// - Three-wire plain: convert low shows the MSB.
// - Bits change only on clock falling edges.
// - Three-wire plain: float at 16th fall or convert rise.
// - Three-wire busy: float until conversion ends.
// - Busy: drive low at end, then shift.
// - Three-wire busy: float at 17th fall or convert rise.
// - Four-wire plain: low input selects, shows MSB.
// - Four-wire plain: float at 16th fall or input rise.
// - Four-wire busy: float at 17th fall or input rise.
// - Chain: both inputs low drives output low when idle or between select reads; a chain read shows the MSB.
// - Input low at convert edge: chain, no busy.
// - Chain: MSB shown as soon as conversion ends.
// - Chain: input feeds shift register on falls.
`timescale 1ns/1ps
`include "adcsr_map.vh"
module adcsr_readout #(
	parameter WIDTH    = `ADCSR_WORD_BITS,
	parameter CONV_CYC = `ADCSR_CONV_CYC
) (
	// Clock, reset and enable.
	input  wire             mclk,
	input  wire             arst_n,
	input  wire             clk_en,
	// Pins from the host.
	input  wire             convert_start_pin,
	input  wire             serial_input_select,
	input  wire             sck,
	// Serial result output, enable low while driven.
	output reg              serial_result_out,
	output reg              serial_result_oe_n,
	// Result word from the conversion core.
	input  wire [WIDTH-1:0] conv_result,
	// Status towards the core.
	output reg              converting,
	output reg              powered_down
);
	// Synchronised pin views and their edges.
	wire cnv_lvl;
	wire cnv_rise;
	wire sdi_lvl;
	wire sdi_rise;
	wire sdi_fall;
	wire sck_lvl;
	wire sck_fall;
	wire sh_msb;

	reg [1:0]  state;        // Sequencer state.
	reg        chain_mode;   // Set when chain mode was picked.
	reg [15:0] conv_cnt;     // Cycles left in the conversion.
	reg [4:0]  fall_cnt;     // Clock falls seen in this read.
	reg        busy_mode;    // Busy bit was placed ahead of the data.
	reg        active;       // Output currently driven with data.
	reg        sh_load;      // Load the shift register this cycle.
	reg        sh_shift;     // Shift the register this cycle.

	adcsr_sync u_cnv (
		.mclk   (mclk),
		.arst_n (arst_n),
		.clk_en (clk_en),
		.pin_in (convert_start_pin),
		.level  (cnv_lvl),
		.rise   (cnv_rise),
		.fall   ()
	);

	adcsr_sync u_sdi (
		.mclk   (mclk),
		.arst_n (arst_n),
		.clk_en (clk_en),
		.pin_in (serial_input_select),
		.level  (sdi_lvl),
		.rise   (sdi_rise),
		.fall   (sdi_fall)
	);

	adcsr_sync u_sck (
		.mclk   (mclk),
		.arst_n (arst_n),
		.clk_en (clk_en),
		.pin_in (sck),
		.level  (sck_lvl),
		.rise   (),
		.fall   (sck_fall)
	);

	adcsr_shift #(
		.WIDTH (WIDTH)
	) u_shift (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.clk_en    (clk_en),
		.load      (sh_load),
		.load_word (conv_result),
		.shift     (sh_shift),
		.shift_in  (chain_mode & sdi_lvl),
		.msb       (sh_msb)
	);

	// Last falling edge number for the current read.
	function [4:0] last_fall;
		input busy;
		begin
			last_fall = busy ? 5'd`ADCSR_LAST_BUSY : 5'd`ADCSR_LAST_PLAIN;
		end
	endfunction

	// Sequencer: conversion, readout and the pin drive.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state              <= `ADCSR_ST_IDLE;
			chain_mode         <= 1'b0;
			conv_cnt           <= 16'h0000;
			fall_cnt           <= 5'h00;
			busy_mode          <= 1'b0;
			active             <= 1'b0;
			sh_load            <= 1'b0;
			sh_shift           <= 1'b0;
			serial_result_out  <= 1'b0;
			serial_result_oe_n <= 1'b1;
			converting         <= 1'b0;
			powered_down       <= 1'b1;
		end else if (clk_en) begin
			sh_load  <= 1'b0;
			sh_shift <= 1'b0;
			// A convert rise outside a conversion starts a new one.
			if (cnv_rise && state != `ADCSR_ST_CONV) begin
				state        <= `ADCSR_ST_CONV;
				chain_mode   <= ~sdi_lvl;
				busy_mode    <= ~sdi_lvl & sck_lvl;
				conv_cnt     <= CONV_CYC[15:0];
				converting   <= 1'b1;
				powered_down <= 1'b0;
				active       <= 1'b0;
				fall_cnt     <= 5'h00;
				serial_result_oe_n <= 1'b1;
			end else begin
				case (state)
				`ADCSR_ST_CONV: begin
					// Convert pin is ignored until the count expires.
					serial_result_oe_n <= 1'b1;
					if (conv_cnt == 16'h0001) begin
						state        <= `ADCSR_ST_READ;
						converting   <= 1'b0;
						powered_down <= 1'b1;
						sh_load      <= 1'b1;
						fall_cnt     <= 5'h00;
						if (chain_mode) begin
							// Chain shows data at once; busy never set here.
							active <= 1'b1;
						end else if (!cnv_lvl || !sdi_lvl) begin
							// Select mode busy: drive low then data follows.
							busy_mode          <= 1'b1;
							active             <= 1'b1;
							serial_result_out  <= 1'b0;
							serial_result_oe_n <= 1'b0;
						end else begin
							busy_mode <= 1'b0;
							active    <= 1'b0;
						end
					end else begin
						conv_cnt <= conv_cnt - 16'h0001;
					end
				end
				`ADCSR_ST_READ: begin
					if (chain_mode) begin
						// Data bits, then upstream data, on every fall.
						if (sck_fall) begin
							sh_shift <= 1'b1;
						end
						// While the word is being loaded the register still holds
						// stale bits, so take the MSB straight from the core word.
						if (sh_load) begin
							serial_result_out <= conv_result[WIDTH-1];
						end else begin
							serial_result_out <= sh_msb;
						end
						serial_result_oe_n <= 1'b0;
					end else if (busy_mode && active && fall_cnt == 5'h00
						&& !sck_fall) begin
						// Busy low bit held until the first fall.
						serial_result_out  <= 1'b0;
						serial_result_oe_n <= 1'b0;
						if (cnv_rise || (sdi_rise && cnv_lvl)) begin
							active             <= 1'b0;
							serial_result_oe_n <= 1'b1;
						end
					end else if (active) begin
						if (cnv_rise || (cnv_lvl && sdi_rise)) begin
							active             <= 1'b0;
							serial_result_oe_n <= 1'b1;
						end else if (sck_fall) begin
							fall_cnt <= fall_cnt + 5'h01;
							if (fall_cnt + 5'h01 == last_fall(busy_mode)) begin
								active             <= 1'b0;
								serial_result_oe_n <= 1'b1;
							end else begin
								// Plain read shifts after the MSB fall.
								if (!busy_mode || fall_cnt != 5'h00) begin
									sh_shift <= 1'b1;
								end
								serial_result_oe_n <= 1'b0;
							end
						end else begin
							serial_result_out  <= sh_msb;
							serial_result_oe_n <= 1'b0;
						end
					end else if (!busy_mode && fall_cnt == 5'h00
						&& ((!cnv_lvl && sdi_lvl) || (cnv_lvl && sdi_fall))) begin
						// Select: convert low (three-wire) or input low.
						active             <= 1'b1;
						serial_result_out  <= sh_msb;
						serial_result_oe_n <= 1'b0;
					end else if (!cnv_lvl && !sdi_lvl) begin
						serial_result_out  <= 1'b0;
						serial_result_oe_n <= 1'b0;
					end else begin
						serial_result_oe_n <= 1'b1;
					end
				end
				default: begin
					// Idle after reset: chain-style low drive when both low.
					if (!cnv_lvl && !sdi_lvl) begin
						serial_result_out  <= 1'b0;
						serial_result_oe_n <= 1'b0;
					end else begin
						serial_result_oe_n <= 1'b1;
					end
				end
				endcase
			end
		end
	end
endmodule // adcsr_readout

// [adcsr_map.vh]
// Constants for the converter serial readout block.
`ifndef ADCSR_MAP_VH
`define ADCSR_MAP_VH
// Result word width in bits.
`define ADCSR_WORD_BITS 16
// Conversion time in nanoseconds, figure of the converter core model.
`define ADCSR_CONV_NS 500
// Clock period of mclk in picoseconds.
`define ADCSR_MCLK_PS 4000
// Conversion cycles derived from the time and the clock rate, rounded up.
`define ADCSR_CONV_CYC ((`ADCSR_CONV_NS * 1000 + `ADCSR_MCLK_PS - 1) / `ADCSR_MCLK_PS)
// Falling edge count that ends a read without busy bit.
`define ADCSR_LAST_PLAIN 16
// Falling edge count that ends a read with busy bit.
`define ADCSR_LAST_BUSY 17
// Reset value of the result register.
`define ADCSR_RESULT_RST 16'h0000
// State codes of the readout sequencer.
`define ADCSR_ST_IDLE 2'h0
`define ADCSR_ST_CONV 2'h1
`define ADCSR_ST_READ 2'h2
`endif

// [adcsr_sync.v]
// Two-stage synchroniser with edge detection on the synchronised level.
`timescale 1ns/1ps
module adcsr_sync (
	// Clock, reset and enable.
	input  wire mclk,
	input  wire arst_n,
	input  wire clk_en,
	// Asynchronous pin and its synchronised view.
	input  wire pin_in,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta;   // First stage, read only by the second stage.
	reg sync;   // Second stage, safe to use.
	reg prev;   // Previous synchronised level.

	// Shift the pin through two flops, then keep one more for edges.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else if (clk_en) begin
			meta <= pin_in;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise  = sync & ~prev;
	assign fall  = ~sync & prev;
endmodule // adcsr_sync

// [adcsr_shift.v]
// Result shift register, loaded with a word and shifted MSB first.
`timescale 1ns/1ps
`include "adcsr_map.vh"
module adcsr_shift #(
	parameter WIDTH = `ADCSR_WORD_BITS
) (
	// Clock, reset and enable.
	input  wire             mclk,
	input  wire             arst_n,
	input  wire             clk_en,
	// Load and shift controls.
	input  wire             load,
	input  wire [WIDTH-1:0] load_word,
	input  wire             shift,
	input  wire             shift_in,
	// Current most significant bit.
	output wire             msb
);
	reg [WIDTH-1:0] word;   // Held result bits.

	// Load takes priority; a shift moves the word one place toward the MSB.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			word <= `ADCSR_RESULT_RST;
		end else if (clk_en) begin
			if (load) begin
				word <= load_word;
			end else if (shift) begin
				word <= {word[WIDTH-2:0], shift_in};
			end
		end
	end

	assign msb = word[WIDTH-1];
endmodule // adcsr_shift

// [adcsr_monitor.sv]
// Concurrent checks on the ports of the converter serial readout.
`timescale 1ns/1ps
module adcsr_monitor #(
	parameter WIDTH    = 16,
	parameter CONV_CYC = 8
) (
	// Clock, reset and enable.
	input wire             mclk,
	input wire             arst_n,
	input wire             clk_en,
	// Host pins.
	input wire             convert_start_pin,
	input wire             serial_input_select,
	input wire             sck,
	// Serial output, core word and status.
	input wire             serial_result_out,
	input wire             serial_result_oe_n,
	input wire [WIDTH-1:0] conv_result,
	input wire             converting,
	input wire             powered_down
);
	reg [15:0] conv_cnt; // Cycles spent converting so far.
	reg        sel;      // Select level seen just before the conversion began.
	// Count conversion cycles and freeze the mode level while converting.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			conv_cnt <= 16'h0000;
			sel      <= 1'b0;
		end else begin
			conv_cnt <= converting ? conv_cnt + 16'h0001 : 16'h0000;
			if (!converting) begin
				sel <= serial_input_select;
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	chk_conv_length: assert property ($fell(converting) |-> conv_cnt == CONV_CYC)
		else $error("conversion length wrong");
	chk_power_state: assert property (powered_down == !converting)
		else $error("power state disagrees with conversion");
	chk_start_float: assert property ($rose(converting) && serial_input_select |-> serial_result_oe_n)
		else $error("output driven at select start");
	chk_hold_float: assert property (converting && sel |-> serial_result_oe_n)
		else $error("output driven during select conversion");
	chk_busy_low: assert property ($fell(converting) && sel && !(convert_start_pin && serial_input_select)
		|-> ##[0:2] (!serial_result_oe_n && !serial_result_out))
		else $error("busy low missing at end");
	chk_chain_msb: assert property ($fell(converting) && !sel
		|-> ##[0:2] (!serial_result_oe_n && serial_result_out == conv_result[WIDTH-1]))
		else $error("chain msb missing at end");
	chk_both_low: assert property ((!convert_start_pin && !serial_input_select && !converting) [*8]
		|-> !serial_result_oe_n && !serial_result_out)
		else $error("output not driven low with both pins low");
	chk_bit_steady: assert property ($rose(sck) |-> ##5 $stable(serial_result_out) [*8])
		else $error("output bit moved while clock high");
endmodule // adcsr_monitor
bind adcsr_readout adcsr_monitor #(.WIDTH(WIDTH), .CONV_CYC(CONV_CYC)) mon (.mclk(mclk),
	.arst_n(arst_n), .clk_en(clk_en), .convert_start_pin(convert_start_pin),
	.serial_input_select(serial_input_select), .sck(sck), .serial_result_out(serial_result_out),
	.serial_result_oe_n(serial_result_oe_n), .conv_result(conv_result),
	.converting(converting), .powered_down(powered_down));

// [adcsr_host.sv]
// Host model that clocks the serial link and collects the returned bits.
`timescale 1ns/1ps
module adcsr_host (
	// Serial clock towards the converter.
	output reg  sck,
	// Converter output and its enable.
	input  wire serial_result_out,
	input  wire serial_result_oe_n
);
	reg  [63:0] got;                                              // Captured bits, newest in bit 0.
	wire        line = serial_result_oe_n ? 1'b1 : serial_result_out; // Pull-up when floating.
	initial begin
		sck = 1'b0;
		got = 64'h0000_0000_0000_0000;
	end
	// Give n falling edges at 160 ns; the clock stands low between frames.
	task burst(input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				#80 sck = 1'b1;
				got = {got[62:0], line};
				#80 sck = 1'b0;
			end
			#80;
		end
	endtask
endmodule // adcsr_host

// [adcsr_readout_test.sv]
// Self-checking bench for the converter serial readout.
`timescale 1ns/1ps
module adcsr_readout_test;
	localparam [15:0] result_word = 16'ha5c3; // Word offered by the core.
	reg     mclk = 1'b0;
	reg     arst_n = 1'b0;
	reg     conv_pin = 1'b0;
	reg     sel_pin = 1'b1;
	reg     clk_en = 1'b1;                // Run enable, dropped once to test the freeze.
	reg     [15:0] core_word = result_word; // Word handed over by the core.
	wire    sck, dout, oe_n, busy, pdn;
	integer fail_count = 0;
	integer samples_checked = 0;
	always #2 mclk = ~mclk;
	adcsr_readout #(.CONV_CYC(16)) dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
		.convert_start_pin(conv_pin), .serial_input_select(sel_pin), .sck(sck),
		.serial_result_out(dout), .serial_result_oe_n(oe_n), .conv_result(core_word),
		.converting(busy), .powered_down(pdn));
	adcsr_host host (.sck(sck), .serial_result_out(dout), .serial_result_oe_n(oe_n));
	// Compare and count; report a mismatch at once.
	task check(input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask
	task tick(input integer n);
		begin
			repeat (n) @(negedge mclk);
		end
	endtask
	// Park convert low, then raise it with the chosen mode level.
	task start(input sel_level);
		begin
			sel_pin = sel_level;
			conv_pin = 1'b0;
			tick(30);
			conv_pin = 1'b1;
			tick(6);
		end
	endtask
	task t3_plain;
		begin
			start(1'b1);
			check(oe_n, 1'b1);
			conv_pin = 1'b0;
			tick(2);
			conv_pin = 1'b1;
			tick(30);
			check(pdn, 1'b1);
			conv_pin = 1'b0;
			tick(8);
			check({oe_n, dout}, {1'b0, result_word[15]});
			host.burst(16);
			check(host.got[15:0], result_word);
			check(oe_n, 1'b1);
		end
	endtask
	task t3_busy;
		begin
			start(1'b1);
			conv_pin = 1'b0;
			tick(6);
			check(oe_n, 1'b1);
			tick(24);
			check({oe_n, dout}, 2'b00);
			host.burst(8);
			check(host.got[7:0], {1'b0, result_word[15:9]});
			tick(1);
			conv_pin = 1'b1;
			tick(8);
			check(oe_n, 1'b1);
		end
	endtask
	task w4_busy;
		begin
			start(1'b1);
			sel_pin = 1'b0;
			tick(30);
			check({oe_n, dout}, 2'b00);
			host.burst(17);
			check(host.got[16:0], {1'b0, result_word});
			check(oe_n, 1'b1);
		end
	endtask
	task w4_plain;
		begin
			start(1'b1);
			tick(30);
			check(oe_n, 1'b1);
			sel_pin = 1'b0;
			tick(8);
			check({oe_n, dout}, {1'b0, result_word[15]});
			host.burst(4);
			check(host.got[3:0], result_word[15:12]);
			tick(1);
			sel_pin = 1'b1;
			tick(8);
			check(oe_n, 1'b1);
			conv_pin = 1'b0;
			sel_pin = 1'b0;
			tick(10);
			check({oe_n, dout}, 2'b00);
		end
	endtask
	task chain_read;
		begin
			tick(30);
			check({oe_n, dout}, 2'b00);
			conv_pin = 1'b1;
			tick(30);
			check({oe_n, dout}, {1'b0, result_word[15]});
			sel_pin = 1'b1;
			// A clock fall while the block is frozen must not shift the word.
			clk_en = 1'b0;
			host.burst(1);
			clk_en = 1'b1;
			tick(4);
			check({oe_n, dout}, {1'b0, result_word[15]});
			host.burst(32);
			check(host.got[31:0], {result_word, 16'hffff});
		end
	endtask
	// Print the counts and the verdict, then stop.
	task wrap_up;
		begin
			$display("checks %0d, mismatches %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		tick(3);
		arst_n = 1'b1;
		tick(4);
		t3_plain;
		t3_busy;
		w4_busy;
		w4_plain;
		chain_read;
		wrap_up;
	end
	// Cut a hang short well beyond the expected run time.
	initial begin
		#60000;
		fail_count = fail_count + 1;
		wrap_up;
	end
endmodule // adcsr_readout_test
